/* cps_pkg.sv */
package cps_pkg;
	// Management addressing
	localparam logic [4:0] CPS_DEV_SPACE = 5'h07;
	localparam logic [15:0] CPS_ADDR_RESOLVE = 16'hFFFD;
	localparam logic [15:0] CPS_ADDR_TEST = 16'hFFFE;
	localparam logic [15:0] CPS_ADDR_EXP_ACCESS = 16'hFFF7;
	localparam logic [15:0] CPS_ADDR_EXP_DATA = 16'hFFF5;
	localparam logic [15:0] CPS_ADDR_MISC_CTRL = 16'hFFF8;
	localparam logic [15:0] CPS_ADDR_RX_ERR_CNT = 16'hFFF4;
	localparam logic [15:0] CPS_ADDR_FIFO_LSB = 16'hFFF0;
	// Expansion index codes held in access bits 11:0
	localparam logic [11:0] CPS_EXP_PKT_CNT = 12'hF00;
	localparam logic [11:0] CPS_EXP_OP_MODE = 12'hF42;
	localparam logic [11:0] CPS_EXP_PATTERN = 12'hF46;
	// Field positions
	localparam int CPS_SHADOW_BIT = 15;
	localparam int CPS_NO_GIG_BIT = 14;
	localparam int CPS_NO_100_BIT = 13;
	localparam int CPS_DOWNGRADE_BIT = 12;
	localparam int CPS_CRC_MODE_BIT = 15;
	localparam int CPS_SWAP_BIT = 7;
	localparam int CPS_PKT_DIR_BIT = 11;
	localparam int CPS_FIFO_MSB_BIT = 14;
	localparam int CPS_FIFO_LSB_BIT = 0;
	// Masks of writable storage
	localparam logic [15:0] CPS_RESOLVE_RSV_MASK = 16'h00C3;
	localparam logic [15:0] CPS_SEED_RW_MASK = 16'h07FF;
	localparam logic [15:0] CPS_PATTERN_RW_MASK = 16'hC000;
	// Reset values
	localparam logic [15:0] CPS_TEST_RESET = 16'h0000;
	localparam logic [15:0] CPS_REG_RESET = 16'h0000;
	localparam logic [1:0] CPS_FIFO_RESET = 2'h0;
	// Counter saturation values
	localparam logic [15:0] CPS_PKT_SAT = 16'hFFF8;
	localparam logic [15:0] CPS_ERR_SAT = 16'hFFFF;
endpackage : cps_pkg

/* cps_cnt_if.sv */
interface cps_cnt_if;
	logic inc;
	logic clr;
	logic [15:0] value;
	modport owner (output inc, output clr, input value);
	modport counter (input inc, input clr, output value);
endinterface : cps_cnt_if

/* cps_sat_counter.sv */
module cps_sat_counter
	import cps_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] SAT = CPS_PKT_SAT
) (
	input wire logic clk, // System clock
	input wire logic reset, // Async reset, active high
	cps_cnt_if.counter cnt // Increment, clear and value
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	wire at_sat = (count >= SAT);

	// Clear then count; an event in the clearing cycle is kept as one
	assign next_count = cnt.clr ? WIDTH'(cnt.inc) : ((cnt.inc && !at_sat) ? count + 1'b1 : count);

	// Counter storage
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign cnt.value = 16'(count);
endmodule : cps_sat_counter

/* cps_status_test_regs.sv */
// Function
// - Address FFFD maps to resolution status when bit 15 set, else seed register.
// - Status bit 14 set stops gigabit half and full duplex advertisement.
// - Status bit 13 set stops 100BASE-TX half and full duplex advertisement.
// - Bit 12 latches a speed downgrade until the register is read.
// - Bits 11 to 8 latch the resolved mode until the next read.
// - Bits 5 to 2 latch resolved mode without link; clear on read.
// - Bits 12 to 8 and 5 to 2 clear when negotiation is disabled or restarted.
// - Test bit 15 turns error counter into CRC counter, counting later errors.
// - Forced 100BASE-TX with bit 7 set transmits pair 1, receives pair 0.
// - Pair swap bit ignored while auto-negotiation is enabled.
// - Access index F00 routes the data register to the packet counter.
// - Index F42 and F46 select mode status and pattern status entries.
// - Packet counter is 16 bits, clears on read, saturates at FFF8.
// - Misc control bit 11 chooses receive or transmit packet counting.
// - Serial link bit needs copper link too in SGMII or converter mode.
// - Serial speed 10 gigabit, 01 hundred; bit 12 full duplex.
// - Copper link bit 11, speed bits 10:9, duplex bit 8.
// - Bit 7 energy detect, bit 6 filtered signal detect, bit 5 sync.
// - Two-bit FIFO elasticity: MSB in pattern bit 14, LSB elsewhere bit 0.
// - All registers reachable through clause 45 access in this device space.
module cps_status_test_regs
	import cps_pkg::*;
(
	input wire logic clk, // 100 MHz management clock
	input wire logic reset, // Async reset, active high
	input wire logic [4:0] mgmt_dev, // Device space id of the access
	input wire logic [15:0] mgmt_addr, // Register address
	input wire logic mgmt_wr, // Write strobe, one cycle
	input wire logic mgmt_rd, // Read strobe, one cycle
	input wire logic [15:0] mgmt_wdata, // Write data
	output logic [15:0] mgmt_rdata, // Read data, held until next read
	output logic mgmt_rvalid, // Read data valid pulse
	input wire logic an_enable, // Control register bit 12
	input wire logic an_restart, // Control register bit 9 pulse
	input wire logic forced_100tx, // Forced 100BASE-TX operation
	input wire logic no_gig_adv, // Downgrade logic withdraws gigabit
	input wire logic no_100_adv, // Downgrade logic withdraws 100TX
	input wire logic downgrade_evt, // Speed downgrade pulse
	input wire logic [3:0] resolve_evt, // Resolved gig FD, gig HD, 100 FD, 100 HD
	input wire logic [3:0] nolink_evt, // Same modes resolved, link never up
	input wire logic [3:0] seed_flags, // Seed register status bits 14:11
	input wire logic rx_err_evt, // Receiver error pulse
	input wire logic crc_err_evt, // CRC error pulse
	input wire logic rx_pkt_evt, // Received packet pulse
	input wire logic tx_pkt_evt, // Transmitted packet pulse
	input wire logic serial_link_raw, // Serial side link good
	input wire logic fiber_mode, // Fiber mode, no copper dependency
	input wire logic [1:0] serial_speed, // Serial speed code
	input wire logic serial_duplex, // Serial full duplex
	input wire logic copper_link, // Copper link up
	input wire logic [1:0] copper_speed, // Copper speed code
	input wire logic copper_duplex, // Copper full duplex
	input wire logic copper_energy, // Copper energy detected
	input wire logic fiber_sd_pin, // Filtered signal detect pin, async
	input wire logic serial_sync, // Serial PCS sync valid
	input wire logic [4:0] op_mode, // Operating mode code
	output logic adv_gig_en, // Gigabit abilities may be advertised
	output logic adv_100_en, // 100TX abilities may be advertised
	output logic line_pair_swap, // Transmit on pair 1, receive on pair 0
	output logic crc_count_mode, // Error counter counts CRC errors
	output logic [1:0] fifo_elasticity // Transmit FIFO elasticity code
);
	logic shadow_sel;
	logic [15:0] resolve_rsv;
	logic [12:0] resolve_lat;
	logic [12:0] next_resolve_lat;
	logic [15:0] seed_reg;
	logic [15:0] test_reg;
	logic [15:0] exp_access;
	logic [15:0] misc_ctrl;
	logic [15:0] fifo_lsb_reg;
	logic [15:0] pattern_reg;
	logic sd_meta;
	logic sd_sync;
	logic [15:0] next_rdata;

	cps_cnt_if pkt_cnt();
	cps_cnt_if err_cnt();

	// Access decode, only this device space answers
	wire dev_hit = (mgmt_dev == CPS_DEV_SPACE);
	wire wr_hit = mgmt_wr && dev_hit;
	wire rd_hit = mgmt_rd && dev_hit;
	wire sel_resolve = (mgmt_addr == CPS_ADDR_RESOLVE);
	wire sel_test = (mgmt_addr == CPS_ADDR_TEST);
	wire sel_access = (mgmt_addr == CPS_ADDR_EXP_ACCESS);
	wire sel_data = (mgmt_addr == CPS_ADDR_EXP_DATA);
	wire sel_misc = (mgmt_addr == CPS_ADDR_MISC_CTRL);
	wire sel_err = (mgmt_addr == CPS_ADDR_RX_ERR_CNT);
	wire sel_lsb = (mgmt_addr == CPS_ADDR_FIFO_LSB);
	wire [11:0] exp_index = exp_access[11:0];
	wire exp_pkt = (exp_index == CPS_EXP_PKT_CNT);
	wire exp_mode = (exp_index == CPS_EXP_OP_MODE);
	wire exp_pat = (exp_index == CPS_EXP_PATTERN);

	// Shared address: bit 15 of the write picks the shadow target
	wire wr_resolve = wr_hit && sel_resolve && mgmt_wdata[CPS_SHADOW_BIT];
	wire wr_seed = wr_hit && sel_resolve && !mgmt_wdata[CPS_SHADOW_BIT];
	wire rd_resolve = rd_hit && sel_resolve && shadow_sel;

	// Resolution status latches
	wire an_clear = !an_enable || an_restart;
	wire [12:0] resolve_set = {downgrade_evt, resolve_evt, 2'b00, nolink_evt, 2'b00};
	always_comb begin
		next_resolve_lat = rd_resolve ? 13'h0000 : resolve_lat;
		next_resolve_lat = next_resolve_lat | resolve_set;
		if (an_clear) begin
			next_resolve_lat = 13'h0000;
		end
	end

	// Serial link needs copper link unless in fiber mode
	wire serial_link_up = serial_link_raw && (fiber_mode || copper_link);
	wire [15:0] op_mode_word = {serial_link_up, serial_speed, serial_duplex,
		copper_link, copper_speed, copper_duplex,
		copper_energy, sd_sync, serial_sync, op_mode};
	wire [15:0] pattern_word = pattern_reg & CPS_PATTERN_RW_MASK;
	wire [15:0] resolve_word = {1'b1, no_gig_adv, no_100_adv, resolve_lat[12:8],
		resolve_rsv[7:6], resolve_lat[5:2], resolve_rsv[1:0]};
	wire [15:0] seed_word = {1'b0, seed_flags, seed_reg[10:0]};
	wire [15:0] exp_word = exp_pkt ? pkt_cnt.value : (exp_mode ? op_mode_word : (exp_pat ? pattern_word : 16'h0000));

	// Read selection, unmapped addresses read as zero
	always_comb begin
		next_rdata = 16'h0000;
		if (sel_resolve) begin
			next_rdata = shadow_sel ? resolve_word : seed_word;
		end else if (sel_test) begin
			next_rdata = test_reg;
		end else if (sel_access) begin
			next_rdata = exp_access;
		end else if (sel_data) begin
			next_rdata = exp_word;
		end else if (sel_misc) begin
			next_rdata = misc_ctrl;
		end else if (sel_err) begin
			next_rdata = err_cnt.value;
		end else if (sel_lsb) begin
			next_rdata = fifo_lsb_reg;
		end
	end

	// Packet counter direction chosen by misc control bit 11
	assign pkt_cnt.inc = misc_ctrl[CPS_PKT_DIR_BIT] ? tx_pkt_evt : rx_pkt_evt;
	assign pkt_cnt.clr = rd_hit && sel_data && exp_pkt;

	// Error counter source; restart count when CRC mode is switched on
	wire crc_mode_rise = wr_hit && sel_test && mgmt_wdata[CPS_CRC_MODE_BIT] && !test_reg[CPS_CRC_MODE_BIT];
	assign err_cnt.inc = test_reg[CPS_CRC_MODE_BIT] ? crc_err_evt : rx_err_evt;
	assign err_cnt.clr = (rd_hit && sel_err) || crc_mode_rise;

	cps_sat_counter #(.WIDTH(16), .SAT(CPS_PKT_SAT)) u_pkt_counter (
		.clk(clk),
		.reset(reset),
		.cnt(pkt_cnt)
	);

	cps_sat_counter #(.WIDTH(16), .SAT(CPS_ERR_SAT)) u_err_counter (
		.clk(clk),
		.reset(reset),
		.cnt(err_cnt)
	);

	// Swap applies only in forced 100BASE-TX with negotiation off
	wire next_swap = test_reg[CPS_SWAP_BIT] && forced_100tx && !an_enable;

	// Signal detect pin synchroniser
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sd_meta <= 1'b0;
			sd_sync <= 1'b0;
		end else begin
			sd_meta <= fiber_sd_pin;
			sd_sync <= sd_meta;
		end
	end

	// Resolution status and seed storage
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shadow_sel <= 1'b0;
			resolve_rsv <= CPS_REG_RESET;
			seed_reg <= CPS_REG_RESET;
			resolve_lat <= 13'h0000;
		end else begin
			resolve_lat <= next_resolve_lat;
			if (wr_hit && sel_resolve) begin
				shadow_sel <= mgmt_wdata[CPS_SHADOW_BIT];
			end
			if (wr_resolve) begin
				resolve_rsv <= mgmt_wdata & CPS_RESOLVE_RSV_MASK;
			end
			if (wr_seed) begin
				seed_reg <= mgmt_wdata & CPS_SEED_RW_MASK;
			end
		end
	end

	// Test, expansion access, misc control and FIFO setting storage
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			test_reg <= CPS_TEST_RESET;
			exp_access <= CPS_REG_RESET;
			misc_ctrl <= CPS_REG_RESET;
			fifo_lsb_reg <= CPS_REG_RESET;
			pattern_reg <= CPS_REG_RESET;
		end else if (wr_hit) begin
			if (sel_test) begin
				test_reg <= mgmt_wdata;
			end
			if (sel_access) begin
				exp_access <= mgmt_wdata;
			end
			if (sel_misc) begin
				misc_ctrl <= mgmt_wdata;
			end
			if (sel_lsb) begin
				fifo_lsb_reg <= mgmt_wdata;
			end
			if (sel_data && exp_pat) begin
				pattern_reg <= mgmt_wdata & CPS_PATTERN_RW_MASK;
			end
		end
	end

	// Registered outputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mgmt_rdata <= 16'h0000;
			mgmt_rvalid <= 1'b0;
			adv_gig_en <= 1'b1;
			adv_100_en <= 1'b1;
			line_pair_swap <= 1'b0;
			crc_count_mode <= 1'b0;
			fifo_elasticity <= CPS_FIFO_RESET;
		end else begin
			mgmt_rvalid <= rd_hit;
			if (rd_hit) begin
				mgmt_rdata <= next_rdata;
			end
			adv_gig_en <= !no_gig_adv;
			adv_100_en <= !no_100_adv;
			line_pair_swap <= next_swap;
			crc_count_mode <= test_reg[CPS_CRC_MODE_BIT];
			fifo_elasticity <= {pattern_reg[CPS_FIFO_MSB_BIT], fifo_lsb_reg[CPS_FIFO_LSB_BIT]};
		end
	end
endmodule : cps_status_test_regs

/* cps_status_test_regs_assertions.sv */
module cps_regs_chk
	import cps_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic reset, // Async reset
	input wire logic [4:0] mgmt_dev, // Device space
	input wire logic [15:0] mgmt_addr, // Address
	input wire logic mgmt_wr, // Write strobe
	input wire logic mgmt_rd, // Read strobe
	input wire logic [15:0] mgmt_wdata, // Write data
	input wire logic [15:0] mgmt_rdata, // Read data
	input wire logic mgmt_rvalid, // Read answer
	input wire logic an_enable, // Negotiation on
	input wire logic forced_100tx, // Forced 100TX
	input wire logic no_gig_adv, // Gigabit withdrawn
	input wire logic no_100_adv, // 100TX withdrawn
	input wire logic adv_gig_en, // Gigabit advertise
	input wire logic adv_100_en, // 100TX advertise
	input wire logic line_pair_swap, // Pair swap
	input wire logic crc_count_mode, // CRC counting
	input wire logic [1:0] fifo_elasticity // FIFO code
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Read answers, refusals, held data and control outputs
	a_read_answer: assert property (mgmt_rd && mgmt_dev == CPS_DEV_SPACE |=> mgmt_rvalid)
		else $error("read without answer");
	a_other_space: assert property (!(mgmt_rd && mgmt_dev == CPS_DEV_SPACE) |=> !mgmt_rvalid)
		else $error("answer without accepted read");
	a_rdata_hold: assert property (!(mgmt_rd && mgmt_dev == CPS_DEV_SPACE) |=> $stable(mgmt_rdata))
		else $error("read data changed between reads");
	a_gig_adv: assert property (!$past(reset) |-> adv_gig_en == !$past(no_gig_adv))
		else $error("gigabit advertise wrong");
	a_fast_adv: assert property (!$past(reset) |-> adv_100_en == !$past(no_100_adv))
		else $error("100TX advertise wrong");
	a_swap_gate: assert property (an_enable |=> !line_pair_swap)
		else $error("swap while negotiating");
	a_swap_cause: assert property (line_pair_swap |-> $past(forced_100tx) && !$past(an_enable))
		else $error("swap outside forced 100TX");
	a_crc_follow: assert property (mgmt_wr && mgmt_dev == CPS_DEV_SPACE && mgmt_addr == CPS_ADDR_TEST
		|-> ##2 crc_count_mode == $past(mgmt_wdata[CPS_CRC_MODE_BIT], 2))
		else $error("crc mode not following test bit");
	a_fifo_lsb: assert property (mgmt_wr && mgmt_dev == CPS_DEV_SPACE && mgmt_addr == CPS_ADDR_FIFO_LSB
		|-> ##2 fifo_elasticity[0] == $past(mgmt_wdata[0], 2))
		else $error("fifo low bit not following");
endmodule : cps_regs_chk

bind cps_status_test_regs cps_regs_chk u_chk (.clk, .reset, .mgmt_dev, .mgmt_addr, .mgmt_wr, .mgmt_rd,
	.mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .an_enable, .forced_100tx, .no_gig_adv, .no_100_adv,
	.adv_gig_en, .adv_100_en, .line_pair_swap, .crc_count_mode, .fifo_elasticity);

/* cps_mgmt_model.sv */
module cps_mgmt_model
	import cps_pkg::*;
(
	input wire logic clk, // Management clock
	input wire logic [15:0] mgmt_rdata, // Read data
	input wire logic mgmt_rvalid, // Read answer
	output logic [4:0] mgmt_dev, // Device space
	output logic [15:0] mgmt_addr, // Address
	output logic mgmt_wr, // Write strobe
	output logic mgmt_rd, // Read strobe
	output logic [15:0] mgmt_wdata // Write data
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		{mgmt_dev, mgmt_addr, mgmt_wr, mgmt_rd, mgmt_wdata} = '0;
	end
	// One write; address and data scrambled once released
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		mgmt_dev = CPS_DEV_SPACE;
		mgmt_addr = a;
		mgmt_wdata = d;
		mgmt_wr = 1'b1;
		@(negedge clk);
		mgmt_wr = 1'b0;
		mgmt_addr = ~a;
		mgmt_wdata = ~d;
	endtask : wr
	// One read; the answer stands for the one cycle after the strobe edge
	task rd(input logic [4:0] dv, input logic [15:0] a, output logic [15:0] d, output logic v);
		@(negedge clk);
		mgmt_dev = dv;
		mgmt_addr = a;
		mgmt_rd = 1'b1;
		@(negedge clk);
		v = mgmt_rvalid;
		d = mgmt_rdata;
		mgmt_rd = 1'b0;
		mgmt_addr = ~a;
	endtask : rd
endmodule : cps_mgmt_model

/* testbench.sv */
module testbench
	import cps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset, mgmt_wr, mgmt_rd, mgmt_rvalid, an_enable, an_restart, forced_100tx, no_gig_adv, no_100_adv;
	logic downgrade_evt, rx_err_evt, crc_err_evt, rx_pkt_evt, tx_pkt_evt, serial_link_raw, fiber_mode, v;
	logic serial_duplex, copper_link, copper_duplex, copper_energy, fiber_sd_pin, serial_sync, adv_gig_en, adv_100_en;
	logic line_pair_swap, crc_count_mode;
	logic [1:0] serial_speed, copper_speed, fifo_elasticity, kk;
	logic [3:0] resolve_evt, nolink_evt, seed_flags;
	logic [4:0] mgmt_dev, op_mode;
	logic [15:0] mgmt_addr, mgmt_wdata, mgmt_rdata, d;
	logic [31:0] seed = 32'h6568, r;
	int fail_count = 0, cmp_count = 0, cyc = 0;
	cps_status_test_regs uut (.clk, .reset, .mgmt_dev, .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata, .mgmt_rdata,
		.mgmt_rvalid, .an_enable, .an_restart, .forced_100tx, .no_gig_adv, .no_100_adv, .downgrade_evt, .resolve_evt,
		.nolink_evt, .seed_flags, .rx_err_evt, .crc_err_evt, .rx_pkt_evt, .tx_pkt_evt, .serial_link_raw, .fiber_mode,
		.serial_speed, .serial_duplex, .copper_link, .copper_speed, .copper_duplex, .copper_energy, .fiber_sd_pin,
		.serial_sync, .op_mode, .adv_gig_en, .adv_100_en, .line_pair_swap, .crc_count_mode, .fifo_elasticity);
	cps_mgmt_model mgr (.clk, .mgmt_rdata, .mgmt_rvalid, .mgmt_dev, .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata);
	// Clock and hang guard
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			fail_count++;
			report_and_stop();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Expected resolution word for one set of events
	function automatic logic [15:0] resolved_common_mode(input logic [31:0] x);
		return {1'b1, x[0], x[1], x[2], x[7:4], 2'b00, x[11:8], 2'b00};
	endfunction : resolved_common_mode
	function automatic logic [15:0] opw();
		return {serial_link_raw & (fiber_mode | copper_link), serial_speed, serial_duplex, copper_link, copper_speed,
			copper_duplex, copper_energy, fiber_sd_pin, serial_sync, op_mode};
	endfunction : opw
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task rchk(input logic [15:0] a, input string n, input logic [15:0] e, input logic [15:0] m);
		mgr.rd(CPS_DEV_SPACE, a, d, v);
		chk("rvalid", 16'h0001, {15'h0, v});
		chk(n, e & m, d & m);
	endtask : rchk
	// Downgrade, resolution and no-link events in one cycle
	task pulse(input logic [31:0] x);
		@(negedge clk);
		{no_gig_adv, no_100_adv, downgrade_evt, resolve_evt, nolink_evt} = {x[0], x[1], x[2], x[7:4], x[11:8]};
		@(negedge clk);
		{downgrade_evt, resolve_evt, nolink_evt} = '0;
	endtask : pulse
	task report_and_stop();
		if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop
	initial begin
		{an_restart, forced_100tx, no_gig_adv, no_100_adv, downgrade_evt, resolve_evt, nolink_evt, seed_flags} = '0;
		{rx_err_evt, crc_err_evt, rx_pkt_evt, tx_pkt_evt, serial_link_raw, fiber_mode, serial_speed} = '0;
		{serial_duplex, copper_link, copper_speed, copper_duplex, copper_energy, fiber_sd_pin, serial_sync, op_mode} = '0;
		an_enable = 1;
		reset = 1;
		repeat (5) @(posedge clk);
		@(negedge clk) reset = 0;
		rchk(CPS_ADDR_TEST, "test reset", CPS_TEST_RESET, 16'hFFFF);
		mgr.wr(CPS_ADDR_RESOLVE, 16'h8000);
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			pulse(r);
			rchk(CPS_ADDR_RESOLVE, "status", resolved_common_mode(r), 16'hFF3C);
			chk("advertise", {14'h0, ~r[0], ~r[1]}, {14'h0, adv_gig_en, adv_100_en});
			rchk(CPS_ADDR_RESOLVE, "status cleared", resolved_common_mode(r) & 16'hE000, 16'hFF3C);
		end
		fork
			mgr.rd(CPS_DEV_SPACE, CPS_ADDR_RESOLVE, d, v);
			pulse(r);
		join
		rchk(CPS_ADDR_RESOLVE, "event at read", resolved_common_mode(r), 16'hFF3C);
		for (int k = 0; k < 2; k++) begin
			pulse(r);
			@(negedge clk) {an_restart, an_enable} = k ? 2'b00 : 2'b11;
			@(negedge clk) {an_restart, an_enable} = 2'b01;
			rchk(CPS_ADDR_RESOLVE, "negotiation clear", resolved_common_mode(r) & 16'hE000, 16'hFF3C);
		end
		r = rnd();
		seed_flags = r[15:12];
		mgr.wr(CPS_ADDR_RESOLVE, {5'h0, r[10:0]});
		rchk(CPS_ADDR_RESOLVE, "seed", {1'b0, r[15:12], r[10:0]}, 16'hFFFF);
		for (int k = 0; k < 2; k++) begin
			r = rnd();
			{r[15], r[7]} = k ? 2'b11 : 2'b00;
			{forced_100tx, an_enable} = 2'b00;
			mgr.wr(CPS_ADDR_TEST, r[15:0]);
			@(negedge clk) forced_100tx = 1;
			rchk(CPS_ADDR_TEST, "test reg", r[15:0], 16'hFFFF);
			chk("swap", {15'h0, r[7]}, {15'h0, line_pair_swap});
			chk("crc mode", {15'h0, r[15]}, {15'h0, crc_count_mode});
			@(negedge clk) an_enable = 1;
			@(negedge clk);
			chk("swap ignored", 16'h0, {15'h0, line_pair_swap});
		end
		repeat (3) begin
			@(negedge clk) {crc_err_evt, rx_err_evt} = 2'b10;
			@(negedge clk) {crc_err_evt, rx_err_evt} = 2'b01;
		end
		@(negedge clk) rx_err_evt = 0;
		rchk(CPS_ADDR_RX_ERR_CNT, "crc count", 16'h0003, 16'hFFFF);
		mgr.wr(CPS_ADDR_EXP_ACCESS, {4'h0, CPS_EXP_PKT_CNT});
		for (int k = 0; k < 2; k++) begin
			mgr.wr(CPS_ADDR_MISC_CTRL, k ? 16'h0800 : 16'h0000);
			mgr.rd(CPS_DEV_SPACE, CPS_ADDR_EXP_DATA, d, v);
			r = rnd();
			for (int i = 0; i < 16; i++) @(negedge clk) {rx_pkt_evt, tx_pkt_evt} = {i < r[3:0], i < r[7:4]};
			@(negedge clk) {rx_pkt_evt, tx_pkt_evt} = 2'b00;
			rchk(CPS_ADDR_EXP_DATA, "packets", {12'h0, k ? r[7:4] : r[3:0]}, 16'hFFFF);
			rchk(CPS_ADDR_EXP_DATA, "packets cleared", 16'h0, 16'hFFFF);
		end
		@(negedge clk) tx_pkt_evt = 1;
		repeat (65540) @(negedge clk);
		tx_pkt_evt = 0;
		rchk(CPS_ADDR_EXP_DATA, "packets saturated", CPS_PKT_SAT, 16'hFFFF);
		mgr.wr(CPS_ADDR_EXP_ACCESS, {4'h0, CPS_EXP_OP_MODE});
		for (int i = 0; i < 6; i++) begin
			r = rnd();
			{serial_link_raw, fiber_mode, serial_speed, serial_duplex, copper_link, copper_speed} = r[7:0];
			{copper_duplex, copper_energy, fiber_sd_pin, serial_sync, op_mode} = r[16:8];
			repeat (3) @(negedge clk);
			rchk(CPS_ADDR_EXP_DATA, "op status", opw(), 16'hFFFF);
		end
		mgr.wr(CPS_ADDR_EXP_ACCESS, {4'h0, CPS_EXP_PATTERN});
		for (int k = 1; k < 4; k++) begin
			kk = k[1:0];
			r = rnd();
			mgr.wr(CPS_ADDR_EXP_DATA, {r[0], kk[1], r[13:0]});
			mgr.wr(CPS_ADDR_FIFO_LSB, {r[15:1], kk[0]});
			rchk(CPS_ADDR_EXP_DATA, "pattern", {r[0], kk[1], 14'h0}, 16'hFFFF);
			chk("fifo", {14'h0, kk}, {14'h0, fifo_elasticity});
		end
		rchk(16'hFFF1, "unmapped", 16'h0, 16'hFFFF);
		mgr.rd(5'h03, CPS_ADDR_TEST, d, v);
		chk("other space", 16'h0, {15'h0, v});
		report_and_stop();
	end
endmodule : testbench
